/* File: core/breaker_cond_mon.sv */
// Purpose: breaker broken-current sums, operation counters, operate-time logs
// Assumes: event inputs are one-cycle pulses on clk_sys; din comes from pins
// Notes: registers reached by a 16-bit holding-register read/write port
// Behaviour
// - each monitored opening adds every phase current to that phase total
// - five bins per phase; a current goes only into its own bin
// - per bin and phase, count openings that added a current there
// - on CT primary change reload default bounds only if all bins zero
// - first bin spans zero to twice CT primary; last bin unbounded
// - sums keep hidden fraction bits; tiny nonzero sums block reload
// - totals read as binary32 over two registers, high half first
// - writing zero to a total clears it
// - every object counts its openings, even when disabled; selected one shown
// - shared trip counter counts enabled protection-trip openings only
// - software may overwrite opening and trip counters
// - each digital input has a rack-out counter; selected one shown
// - rack-out input true means racked out; count each occurrence
// - keep last eight open, close, charge times with timestamps
// - keep a moving average over the last twenty times per category
// - log times while disabled if a monitored object is selected
// - one clear command empties all three logs
// - charge times in seconds, open and close times in milliseconds
// - logged times read newest first as binary32, high half first
// - empty log slots read as zero
// - open or close above 300 ms, charge above 60 s, read as NaN
`timescale 1ns/100ps

module breaker_cond_mon #(
    parameter int N_OBJ = 8,
    parameter int N_DI = 16,
    parameter int CNT_W = 16,
    parameter int CUR_W = 20,
    parameter int TOT_W = 40,
    parameter int MS_CYC = bcm_pkg::MS_CYC
) (
    input wire logic clk_sys, // system clock
    input wire logic rst, // sync reset
    input wire logic func_en, // monitoring function enabled
    input wire logic mon_valid, // a monitored object is selected
    input wire logic [$clog2(N_OBJ)-1:0] mon_sel, // monitored object
    input wire logic [N_OBJ-1:0] obj_open, // per-object open pulse
    input wire logic trip_open, // monitored opened by a trip
    input wire logic [2:0][CUR_W-1:0] cur_in, // phase break currents
    input wire logic [15:0] ct_primary, // CT primary, amps
    input wire logic [N_DI-1:0] din, // digital input pins
    input wire logic [$clog2(N_DI)-1:0] rack_sel, // rack-out input
    input wire logic [2:0] op_start, // operation start pulses
    input wire logic [2:0] op_end, // operation done pulses
    input wire logic [31:0] time_now, // timestamp
    input wire logic clr_logs, // clear logs pulse
    input wire logic rd_en, // register read
    input wire logic [15:0] rd_addr, // read address
    input wire logic wr_en, // register write
    input wire logic [15:0] wr_addr, // write address
    input wire logic [15:0] wr_data, // write data
    output logic [15:0] rd_data, // read data
    output logic rd_valid // read data valid
);
    localparam int TK_W = $clog2(MS_CYC);
    localparam int LN = bcm_pkg::LOG_N;
    localparam int AN = bcm_pkg::AVG_N;

    typedef struct packed {
        logic [2:0][TOT_W-1:0] tot;
        logic [bcm_pkg::NBIN-1:0][2:0][TOT_W-1:0] bsum;
        logic [bcm_pkg::NBIN-1:0][2:0][CNT_W-1:0] bcnt;
        logic [bcm_pkg::NBIN-2:0][31:0] bnd;
        logic [15:0] ct;
        logic [N_OBJ-1:0][CNT_W-1:0] ocnt;
        logic [CNT_W-1:0] tcnt;
        logic [N_DI-1:0] s1;
        logic [N_DI-1:0] s2;
        logic [N_DI-1:0] s3;
        logic [N_DI-1:0] filt;
        logic [N_DI-1:0][CNT_W-1:0] rcnt;
        logic [TK_W-1:0] tick;
        logic [9:0] msc;
        logic [2:0] run;
        logic [2:0][15:0] tmr;
        logic [2:0][LN-1:0][15:0] lt;
        logic [2:0][LN-1:0][31:0] lts;
        logic [2:0][LN-1:0] lv;
        logic [2:0][AN-1:0][15:0] hist;
        logic [2:0][4:0] hcnt;
        logic [2:0][20:0] hsum;
        logic [15:0] wr_hi;
        logic [15:0] rd_data;
        logic rd_valid;
    } state_s;

    state_s s_q;
    state_s d;
    logic open_mon;
    logic ms_tick;
    logic sec_tick;
    logic step;
    logic [2:0] b;
    logic [31:0] wv;
    logic [15:0] ob;
    logic [TOT_W-1:0] fix_w;
    logic [31:0] raw_w;
    logic [31:0] word;
    logic use_fp;
    logic single;
    logic nan_w;
    logic [15:0] ro;
    logic [15:0] tv;
    logic [1:0] c;
    logic [2:0] bin0;

    fp_conv_if #(.W(TOT_W)) cv ();

    fix_to_fp32 #(.W(TOT_W), .FRAC(bcm_pkg::CUR_FRAC)) u_conv (
        .cv(cv.conv)
    );

    // bounds ascend; a current equal to a bound falls in the upper bin
    function automatic logic [2:0] bin_of(input logic [CUR_W-1:0] cur,
                                          input logic [bcm_pkg::NBIN-2:0][31:0] bnd);
        logic [2:0] r;
        r = 3'h0;
        for (int k = 0; k < bcm_pkg::NBIN - 1; k++) begin
            if (32'(cur >> bcm_pkg::CUR_FRAC) >= bnd[k]) r = 3'(k + 1);
        end
        return r;
    endfunction : bin_of

    // ************************************************************
    // read decode
    // ************************************************************
    always_comb begin
        fix_w = '0;
        raw_w = '0;
        use_fp = 1'b0;
        single = 1'b0;
        nan_w = 1'b0;
        c = 2'h0;
        tv = '0;
        ro = rd_addr;
        if (rd_addr < bcm_pkg::TOT_END) begin
            use_fp = 1'b1;
            fix_w = s_q.tot[rd_addr[2:1]];
        end else if (rd_addr >= bcm_pkg::A_BIN && rd_addr < bcm_pkg::BIN_END) begin
            ro = rd_addr - bcm_pkg::A_BIN;
            use_fp = (ro[2:1] != 2'h3);
            if (use_fp) fix_w = s_q.bsum[ro[5:3]][ro[2:1]];
        end else if (rd_addr >= bcm_pkg::A_BCNT && rd_addr < bcm_pkg::BCNT_END) begin
            ro = rd_addr - bcm_pkg::A_BCNT;
            single = 1'b1;
            if (ro[1:0] != 2'h3) raw_w = 32'(s_q.bcnt[ro[4:2]][ro[1:0]]);
        end else if (rd_addr == bcm_pkg::A_OCNT) begin
            single = 1'b1;
            if (mon_valid) raw_w = 32'(s_q.ocnt[mon_sel]);
        end else if (rd_addr == bcm_pkg::A_TCNT) begin
            single = 1'b1;
            raw_w = 32'(s_q.tcnt);
        end else if (rd_addr == bcm_pkg::A_RCNT) begin
            single = 1'b1;
            raw_w = 32'(s_q.rcnt[rack_sel]);
        end else if (rd_addr >= bcm_pkg::A_BND && rd_addr < bcm_pkg::BND_END) begin
            ro = rd_addr - bcm_pkg::A_BND;
            raw_w = s_q.bnd[ro[2:1]];
        end else if (rd_addr >= bcm_pkg::A_LOG && rd_addr < bcm_pkg::LOG_END) begin
            ro = rd_addr - bcm_pkg::A_LOG;
            c = ro[7:6];
            if (!s_q.lv[c][ro[3:1]]) begin
                raw_w = '0;
            end else if (ro[4]) begin
                raw_w = s_q.lts[c][ro[3:1]];
            end else begin
                use_fp = 1'b1;
                tv = s_q.lt[c][ro[3:1]];
                fix_w = TOT_W'(tv) << bcm_pkg::CUR_FRAC;
                nan_w = tv > ((c == 2'(bcm_pkg::CAT_CHARGE)) ? bcm_pkg::LIM_S : bcm_pkg::LIM_MS);
            end
        end else if (rd_addr >= bcm_pkg::A_AVG && rd_addr < bcm_pkg::AVG_END) begin
            ro = rd_addr - bcm_pkg::A_AVG;
            c = ro[2:1];
            use_fp = 1'b1;
            if (s_q.hcnt[c] != 5'h00) fix_w = TOT_W'({s_q.hsum[c], 4'h0} / s_q.hcnt[c]);
        end
        cv.fix = fix_w;
    end

    // ************************************************************
    // next state
    // ************************************************************
    always_comb begin
        d = s_q;
        b = 3'h0;
        step = 1'b0;
        ob = '0;
        word = use_fp ? (nan_w ? bcm_pkg::NAN32 : cv.fp) : raw_w;
        wv = {s_q.wr_hi, wr_data};
        open_mon = mon_valid && obj_open[mon_sel];

        // broken-current sums and bin counters
        if (func_en && open_mon) begin
            for (int p = 0; p < bcm_pkg::NPH; p++) begin
                b = bin_of(cur_in[p], s_q.bnd);
                d.tot[p] = s_q.tot[p] + TOT_W'(cur_in[p]);
                d.bsum[b][p] = s_q.bsum[b][p] + TOT_W'(cur_in[p]);
                if (cur_in[p] != '0) d.bcnt[b][p] = s_q.bcnt[b][p] + CNT_W'(1);
            end
        end

        // full-precision sums decide; a hidden fraction blocks the reload
        d.ct = ct_primary;
        if (ct_primary != s_q.ct && s_q.bsum == '0) begin
            for (int k = 0; k < bcm_pkg::NBIN - 1; k++) begin
                d.bnd[k] = 32'(ct_primary) << (k + 1);
            end
        end

        for (int o = 0; o < N_OBJ; o++) begin
            if (obj_open[o]) d.ocnt[o] = s_q.ocnt[o] + CNT_W'(1);
        end
        if (func_en && mon_valid && trip_open) d.tcnt = s_q.tcnt + CNT_W'(1);

        // rack-out inputs: three stages, change taken once stages two and three agree
        d.s1 = din;
        d.s2 = s_q.s1;
        d.s3 = s_q.s2;
        for (int i = 0; i < N_DI; i++) begin
            if (s_q.s2[i] == s_q.s3[i] && s_q.s3[i] != s_q.filt[i]) begin
                d.filt[i] = s_q.s3[i];
                if (s_q.s3[i]) d.rcnt[i] = s_q.rcnt[i] + CNT_W'(1);
            end
        end

        // millisecond and second ticks, so times carry up to one tick of jitter
        ms_tick = (s_q.tick == TK_W'(MS_CYC - 1));
        sec_tick = ms_tick && (s_q.msc == 10'(bcm_pkg::SEC_MS - 1));
        d.tick = ms_tick ? '0 : s_q.tick + TK_W'(1);
        if (ms_tick) d.msc = sec_tick ? 10'h000 : s_q.msc + 10'h001;

        for (int k = 0; k < bcm_pkg::NCAT; k++) begin
            step = (k == bcm_pkg::CAT_CHARGE) ? sec_tick : ms_tick;
            if (s_q.run[k] && step && s_q.tmr[k] != 16'hffff) d.tmr[k] = s_q.tmr[k] + 16'h0001;
            if (op_start[k]) begin
                d.run[k] = 1'b1;
                d.tmr[k] = 16'h0000;
            end else if (op_end[k] && s_q.run[k]) begin
                d.run[k] = 1'b0;
                if (mon_valid) begin
                    d.lt[k] = {s_q.lt[k][LN-2:0], s_q.tmr[k]};
                    d.lts[k] = {s_q.lts[k][LN-2:0], time_now};
                    d.lv[k] = {s_q.lv[k][LN-2:0], 1'b1};
                    d.hist[k] = {s_q.hist[k][AN-2:0], s_q.tmr[k]};
                    d.hsum[k] = s_q.hsum[k] + 21'(s_q.tmr[k]) - 21'(s_q.hist[k][AN-1]);
                    if (s_q.hcnt[k] != 5'(AN)) d.hcnt[k] = s_q.hcnt[k] + 5'h01;
                end
            end
        end
        if (clr_logs) begin
            d.lt = '0;
            d.lts = '0;
            d.lv = '0;
            d.hist = '0;
            d.hsum = '0;
            d.hcnt = '0;
        end

        // software writes win over a same-cycle increment
        if (wr_en) begin
            if (!wr_addr[0]) d.wr_hi = wr_data;
            if (wr_addr[0] && wr_addr < bcm_pkg::TOT_END && wv[30:0] == '0) d.tot[wr_addr[2:1]] = '0;
            if (wr_addr[0] && wr_addr >= bcm_pkg::A_BIN && wr_addr < bcm_pkg::BIN_END) begin
                ob = wr_addr - bcm_pkg::A_BIN;
                if (ob[2:1] != 2'h3 && wv[30:0] == '0) d.bsum[ob[5:3]][ob[2:1]] = '0;
            end
            if (wr_addr[0] && wr_addr >= bcm_pkg::A_BND && wr_addr < bcm_pkg::BND_END) begin
                ob = wr_addr - bcm_pkg::A_BND;
                d.bnd[ob[2:1]] = wv;
            end
            if (wr_addr == bcm_pkg::A_OCNT && mon_valid) d.ocnt[mon_sel] = CNT_W'(wr_data);
            if (wr_addr == bcm_pkg::A_TCNT) d.tcnt = CNT_W'(wr_data);
        end

        d.rd_valid = rd_en;
        if (rd_en) d.rd_data = single ? word[15:0] : (rd_addr[0] ? word[15:0] : word[31:16]);
    end

    always_ff @(posedge clk_sys) begin
        if (rst) s_q <= '0;
        else s_q <= d;
    end

    assign rd_data = s_q.rd_data;
    assign rd_valid = s_q.rd_valid;

    // ************************************************************
    // checks
    // ************************************************************
    assign bin0 = bin_of(cur_in[0], s_q.bnd);

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    sequence s_open_add;
        func_en && mon_valid && obj_open[mon_sel] && !wr_en;
    endsequence
    sequence s_zero_wr;
        wr_en && wr_addr == bcm_pkg::A_TOT && wr_data == 16'h0000
            ##[1:2] wr_en && wr_addr == 16'h0001 && wr_data == 16'h0000 && s_q.wr_hi == 16'h0000;
    endsequence

    AST_TOTAL_ADD: assert property (s_open_add |=>
        s_q.tot[0] == $past(s_q.tot[0]) + TOT_W'($past(cur_in[0])))
        else $error("phase total not advanced by break current");
    AST_BIN_SUM: assert property (s_open_add |=>
        s_q.bsum[$past(bin0)][0] == $past(s_q.bsum[bin0][0]) + TOT_W'($past(cur_in[0])))
        else $error("bin sum not advanced");
    AST_BIN_CNT: assert property ((s_open_add and (cur_in[0] != '0)) |=>
        s_q.bcnt[$past(bin0)][0] == $past(s_q.bcnt[bin0][0]) + CNT_W'(1))
        else $error("bin counter not advanced");
    AST_RELOAD: assert property ((ct_primary != s_q.ct && s_q.bsum == '0 && !wr_en) |=>
        s_q.bnd[0] == (32'($past(ct_primary)) << 1))
        else $error("default bounds not reloaded");
    AST_NO_RELOAD: assert property ((ct_primary != s_q.ct && s_q.bsum != '0 && !wr_en) |=>
        $stable(s_q.bnd))
        else $error("bounds reloaded with nonzero sums");
    AST_CLEAR: assert property (s_zero_wr |=> s_q.tot[0] == '0)
        else $error("total not cleared by zero write");
    AST_OPEN_CNT: assert property ((mon_valid && obj_open[mon_sel] && !wr_en) |=>
        s_q.ocnt[$past(mon_sel)] == $past(s_q.ocnt[mon_sel]) + CNT_W'(1))
        else $error("object open counter missed an opening");
    AST_TRIP_HOLD: assert property ((!func_en && !wr_en) |=> $stable(s_q.tcnt))
        else $error("trip counter moved while disabled");
    AST_RACK: assert property ((!s_q.filt[rack_sel] && s_q.s2[rack_sel] && s_q.s3[rack_sel]) |=>
        s_q.rcnt[$past(rack_sel)] == $past(s_q.rcnt[rack_sel]) + CNT_W'(1) ##1 $stable(s_q.rcnt[rack_sel]))
        else $error("rack-out occurrence not counted once");
    AST_LOG_CLR: assert property (clr_logs |=> s_q.lv == '0 && s_q.hcnt == '0)
        else $error("logs not cleared");
    AST_EMPTY: assert property ((rd_en && rd_addr == bcm_pkg::A_LOG && !s_q.lv[0][0]) |=>
        rd_valid && rd_data == 16'h0000)
        else $error("empty log slot not zero");
    AST_NAN: assert property ((rd_en && rd_addr == bcm_pkg::A_LOG && s_q.lv[0][0]
        && s_q.lt[0][0] > bcm_pkg::LIM_MS) |=> rd_data == bcm_pkg::NAN32[31:16])
        else $error("long opening time not NaN");
endmodule : breaker_cond_mon

/* File: core/bcm_pkg.sv */
// Purpose: shared constants of the breaker condition monitor
// Assumes: 16-bit holding-register word addresses, 50 MHz system clock
// Notes: every block state resets to all zero

package bcm_pkg;
    // ************************************************************
    // sizes
    // ************************************************************
    localparam int NPH = 3;
    localparam int NBIN = 5;
    localparam int NCAT = 3;
    localparam int LOG_N = 8;
    localparam int AVG_N = 20;
    localparam int CUR_FRAC = 4;
    localparam int CAT_OPEN = 0;
    localparam int CAT_CLOSE = 1;
    localparam int CAT_CHARGE = 2;

    // ************************************************************
    // timing
    // ************************************************************
    localparam int CLK_NS = 20;
    localparam int TICK_NS = 1000000;
    localparam int MS_CYC = TICK_NS / CLK_NS;
    localparam int SEC_MS = 1000;
    localparam logic [15:0] LIM_MS = 16'h012c;
    localparam logic [15:0] LIM_S = 16'h003c;
    localparam logic [31:0] NAN32 = 32'h7fc00000;

    // ************************************************************
    // holding-register map, start inclusive, end exclusive
    // ************************************************************
    localparam logic [15:0] A_TOT = 16'h0000;
    localparam logic [15:0] TOT_END = 16'h0006;
    localparam logic [15:0] A_BIN = 16'h0010;
    localparam logic [15:0] BIN_END = 16'h0038;
    localparam logic [15:0] A_BCNT = 16'h0040;
    localparam logic [15:0] BCNT_END = 16'h0054;
    localparam logic [15:0] A_OCNT = 16'h0060;
    localparam logic [15:0] A_TCNT = 16'h0061;
    localparam logic [15:0] A_RCNT = 16'h0062;
    localparam logic [15:0] A_BND = 16'h0068;
    localparam logic [15:0] BND_END = 16'h0070;
    localparam logic [15:0] A_LOG = 16'h0100;
    localparam logic [15:0] LOG_END = 16'h01c0;
    localparam logic [15:0] A_AVG = 16'h01c0;
    localparam logic [15:0] AVG_END = 16'h01c6;
endpackage : bcm_pkg

/* File: core/fp_conv_if.sv */
// Purpose: carries a fixed-point value to the binary32 converter
// Assumes: converter is purely combinational
// Notes: none
`timescale 1ns/100ps

interface fp_conv_if #(parameter int W = 40);
    logic [W-1:0] fix;
    logic [31:0] fp;
    modport src(output fix, input fp);
    modport conv(input fix, output fp);
endinterface : fp_conv_if

/* File: core/fix_to_fp32.sv */
// Purpose: unsigned fixed point to binary32
// Assumes: W above 24, FRAC fractional bits
// Notes: truncates the mantissa, no rounding
`timescale 1ns/100ps

module fix_to_fp32 #(
    parameter int W = 40,
    parameter int FRAC = 4
) (
    fp_conv_if.conv cv // value in, float out
);
    int pos;
    logic [W-1:0] sh;
    logic [7:0] ex;

    always_comb begin
        pos = 0;
        for (int i = 0; i < W; i++) begin
            if (cv.fix[i]) pos = i;
        end
        sh = cv.fix << (W - 1 - pos);
        ex = 8'(127 + pos - FRAC);
        cv.fp = (cv.fix == '0) ? 32'h00000000 : {1'b0, ex, sh[W-2 -: 23]};
    end
endmodule : fix_to_fp32

/* File: sim/holding_reg_master.sv */
// Purpose: host model reading and writing the holding registers
// Assumes: strobes taken on the rising edge, read answer one cycle later
// Notes: released address and data lines show the inverse of the last value
`timescale 1ns/100ps

module holding_reg_master (
    input wire logic clk_sys, // system clock
    output logic rd_en, // read strobe
    output logic [15:0] rd_addr, // read address
    output logic wr_en, // write strobe
    output logic [15:0] wr_addr, // write address
    output logic [15:0] wr_data, // write data
    input wire logic [15:0] rd_data, // read data
    input wire logic rd_valid // read data valid
);
    initial begin
        rd_en = 1'b0;
        rd_addr = 16'h0000;
        wr_en = 1'b0;
        wr_addr = 16'h0000;
        wr_data = 16'h0000;
    end

    // ************************************************************
    // access tasks, driven at the falling edge
    // ************************************************************
    task automatic rd16(input logic [15:0] a, output logic [15:0] d, output logic ok);
        @(negedge clk_sys);
        rd_en = 1'b1;
        rd_addr = a;
        // answer stands one cycle only, so sample it on the next falling edge
        @(negedge clk_sys);
        ok = rd_valid;
        d = rd_data;
        rd_en = 1'b0;
        rd_addr = ~a;
    endtask : rd16

    task automatic wr16(input logic [15:0] a, input logic [15:0] d);
        @(negedge clk_sys);
        wr_en = 1'b1;
        wr_addr = a;
        wr_data = d;
        @(negedge clk_sys);
        wr_en = 1'b0;
        wr_addr = ~a;
        wr_data = ~d;
    endtask : wr16

    task automatic wr32(input logic [15:0] a, input logic [31:0] d);
        wr16(a, d[31:16]);
        wr16(a + 16'h0001, d[15:0]);
    endtask : wr32
endmodule : holding_reg_master

/* File: sim/testbench.sv */
// Purpose: self-checking bench of the breaker condition monitor
// Assumes: tick shortened to 10 cycles, host model drives the register port
// Notes: operate times checked within one tick of jitter
`timescale 1ns/100ps

module testbench;
    // ************************************************************
    // design and host model
    // ************************************************************
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic func_en = 1'b1;
    logic mon_valid = 1'b1;
    logic [2:0] mon_sel = 3'h2;
    logic [7:0] obj_open = 8'h00;
    logic trip_open = 1'b0;
    logic [2:0][19:0] cur_in = '0;
    logic [15:0] ct_primary = 16'h0000;
    logic [15:0] din = 16'h0000;
    logic [3:0] rack_sel = 4'h5;
    logic [2:0] op_start = 3'h0;
    logic [2:0] op_end = 3'h0;
    logic [31:0] time_now = 32'h00001234;
    logic clr_logs = 1'b0;
    logic rd_en, wr_en, rd_valid;
    logic [15:0] rd_addr, wr_addr, wr_data, rd_data;
    int errors = 0;
    int num_checks = 0;

    always #10 clk_sys = ~clk_sys;

    breaker_cond_mon #(.MS_CYC(10)) DUT (.clk_sys(clk_sys), .rst(rst), .func_en(func_en),
        .mon_valid(mon_valid), .mon_sel(mon_sel), .obj_open(obj_open), .trip_open(trip_open),
        .cur_in(cur_in), .ct_primary(ct_primary), .din(din), .rack_sel(rack_sel), .op_start(op_start),
        .op_end(op_end), .time_now(time_now), .clr_logs(clr_logs), .rd_en(rd_en), .rd_addr(rd_addr),
        .wr_en(wr_en), .wr_addr(wr_addr), .wr_data(wr_data), .rd_data(rd_data), .rd_valid(rd_valid));

    holding_reg_master m (.clk_sys(clk_sys), .rd_en(rd_en), .rd_addr(rd_addr), .wr_en(wr_en),
        .wr_addr(wr_addr), .wr_data(wr_data), .rd_data(rd_data), .rd_valid(rd_valid));

    // ************************************************************
    // helpers
    // ************************************************************
    task automatic rv16(input logic [15:0] a, input logic [15:0] e, input string n);
        logic [15:0] v;
        logic ok;
        m.rd16(a, v, ok);
        num_checks++;
        if ({ok, v} !== {1'b1, e}) begin
            errors++;
            $display("[ERR] %s expected %h seen %h valid %b", n, e, v, ok);
        end
    endtask : rv16

    task automatic rv32(input logic [15:0] a, input logic [31:0] e, input string n);
        rv16(a, e[31:16], n);
        rv16(a + 16'h0001, e[15:0], n);
    endtask : rv32

    // timer phase is free, so a logged time may be one tick off
    task automatic rng(input logic [15:0] a, input logic [15:0] lo, input logic [15:0] hi, input string n);
        logic [15:0] v;
        logic ok;
        m.rd16(a, v, ok);
        num_checks++;
        if ((v >= lo && v <= hi && ok) !== 1'b1) begin
            errors++;
            $display("[ERR] %s expected %h..%h seen %h", n, lo, hi, v);
        end
        rv16(a + 16'h0001, 16'h0000, n);
    endtask : rng

    task automatic opn(input int i, input logic t);
        @(negedge clk_sys);
        obj_open[i] = 1'b1;
        trip_open = t;
        @(negedge clk_sys);
        obj_open = 8'h00;
        trip_open = 1'b0;
        repeat (2) @(negedge clk_sys);
    endtask : opn

    task automatic op(input int c, input int n);
        @(negedge clk_sys);
        op_start[c] = 1'b1;
        @(negedge clk_sys);
        op_start = 3'h0;
        repeat (n) @(negedge clk_sys);
        op_end[c] = 1'b1;
        @(negedge clk_sys);
        op_end = 3'h0;
        repeat (2) @(negedge clk_sys);
    endtask : op

    // long enough for the input synchroniser on both edges
    task automatic rack(input int i);
        @(negedge clk_sys);
        din[i] = 1'b1;
        repeat (8) @(negedge clk_sys);
        din[i] = 1'b0;
        repeat (8) @(negedge clk_sys);
    endtask : rack

    task automatic set_ct(input logic [15:0] v);
        @(negedge clk_sys);
        ct_primary = v;
        repeat (3) @(negedge clk_sys);
    endtask : set_ct

    task automatic results();
        $display("checks %0d mismatches %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : results

    // ************************************************************
    // tests
    // ************************************************************
    initial begin
        repeat (3) @(negedge clk_sys);
        rst = 1'b0;
        rv32(16'h0000, 32'h00000000, "total L1");
        rv16(16'h0060, 16'h0000, "open count");
        $display("test reset done");
        set_ct(16'h0064);
        rv32(16'h0068, 32'h000000c8, "bound 0");
        rv32(16'h006e, 32'h00000640, "bound 3");
        // L1 100 A, L2 exactly on the first bound, L3 none
        cur_in = {20'h00000, 20'h00c80, 20'h00640};
        opn(2, 1'b1);
        rv32(16'h0000, 32'h42c80000, "total L1");
        rv32(16'h0002, 32'h43480000, "total L2");
        rv32(16'h0004, 32'h00000000, "total L3");
        rv32(16'h0010, 32'h42c80000, "bin0 L1");
        rv32(16'h0012, 32'h00000000, "bin0 L2");
        rv32(16'h001a, 32'h43480000, "bin1 L2");
        rv16(16'h0040, 16'h0001, "bin0 L1 count");
        rv16(16'h0045, 16'h0001, "bin1 L2 count");
        rv16(16'h0042, 16'h0000, "bin0 L3 count");
        rv16(16'h0060, 16'h0001, "open count");
        rv16(16'h0061, 16'h0001, "trip count");
        $display("test accumulate done");
        func_en = 1'b0;
        opn(2, 1'b1);
        opn(3, 1'b0);
        rv16(16'h0060, 16'h0002, "open count off");
        rv16(16'h0061, 16'h0001, "trip count off");
        rv32(16'h0000, 32'h42c80000, "total L1 off");
        mon_sel = 3'h3;
        rv16(16'h0060, 16'h0001, "open count obj3");
        rv16(16'h0061, 16'h0001, "trip count obj3");
        mon_sel = 3'h2;
        m.wr16(16'h0060, 16'h0005);
        m.wr16(16'h0061, 16'h0009);
        rv16(16'h0060, 16'h0005, "open count write");
        rv16(16'h0061, 16'h0009, "trip count write");
        $display("test counters done");
        set_ct(16'h0032);
        rv32(16'h0068, 32'h000000c8, "bound kept");
        m.wr32(16'h0010, 32'h00000000);
        m.wr32(16'h001a, 32'h00000000);
        rv32(16'h0010, 32'h00000000, "bin0 L1 cleared");
        rv32(16'h0000, 32'h42c80000, "total L1 kept");
        m.wr32(16'h0000, 32'h00000000);
        rv32(16'h0000, 32'h00000000, "total L1 cleared");
        func_en = 1'b1;
        cur_in = {20'h00000, 20'h00000, 20'h00001};
        opn(2, 1'b0);
        set_ct(16'h003c);
        rv32(16'h0068, 32'h000000c8, "bound kept tiny");
        m.wr32(16'h0010, 32'h00000000);
        set_ct(16'h0046);
        rv32(16'h0068, 32'h0000008c, "bound reload");
        $display("test bin ranges done");
        rack(5);
        rack(5);
        rack(6);
        rv16(16'h0062, 16'h0002, "rack count in5");
        rack_sel = 4'h6;
        rv16(16'h0062, 16'h0001, "rack count in6");
        $display("test rack-out done");
        func_en = 1'b0;
        op(0, 50);
        time_now = 32'h00005678;
        op(0, 3200);
        op(1, 100);
        op(2, 20000);
        rv32(16'h0100, 32'h7fc00000, "open time 0");
        rng(16'h0102, 16'h4080, 16'h40c0, "open time 1");
        rv32(16'h0104, 32'h00000000, "open time 2");
        rv32(16'h0110, 32'h00005678, "open stamp 0");
        rv32(16'h0112, 32'h00001234, "open stamp 1");
        rng(16'h0140, 16'h4110, 16'h4130, "close time 0");
        rng(16'h01c2, 16'h4110, 16'h4130, "close average");
        rng(16'h0180, 16'h3f80, 16'h4040, "charge time 0");
        mon_valid = 1'b0;
        op(1, 20);
        mon_valid = 1'b1;
        rv32(16'h0142, 32'h00000000, "close unselected");
        @(negedge clk_sys);
        clr_logs = 1'b1;
        @(negedge clk_sys);
        clr_logs = 1'b0;
        rv32(16'h0100, 32'h00000000, "open time 0 cleared");
        rv32(16'h0102, 32'h00000000, "open time cleared");
        rv32(16'h0140, 32'h00000000, "close time cleared");
        rv32(16'h0112, 32'h00000000, "open stamp cleared");
        $display("test logs done");
        results();
    end

    // about 24000 cycles expected
    initial begin
        repeat (40000) @(posedge clk_sys);
        errors++;
        $display("[ERR] watchdog expected finish seen hang");
        results();
    end
endmodule : testbench
